// file: csc_pkg.sv
// Shared constants and types for the component sorting comparator
package csc_pkg;

    localparam int NUM_RANGES = 9;
    localparam int NUM_LIMITS = 10;
    localparam logic [3:0] SEC_INDEX = 4'h9;
    localparam int VALUE_W = 32;
    localparam int PCT_W = 16;
    localparam int CLASS_W = 4;
    localparam int CHAN_W = 2;
    localparam int COUNT_W = 20;
    localparam int COUNT_AW = CHAN_W + CLASS_W;
    localparam int COUNT_DEPTH = 64;

    // Values are signed femtofarads; percentages are in 0.01 % steps
    localparam logic [63:0] PCT_SCALE = 64'h0000_0000_0000_2710;
    localparam logic [31:0] BOUND_RESET = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 20'h0_0000;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 20'hF_423F;

    // Minimum ranges used as low-value reference in auto-range operation
    localparam logic [31:0] MIN_RANGE_10NF = 32'h0098_9680;
    localparam logic [31:0] MIN_RANGE_100PF = 32'h0001_86A0;
    localparam logic [31:0] MIN_RANGE_1PF = 32'h0000_03E8;

    // Class codes as reported to the host
    localparam logic [CLASS_W-1:0] CLASS_UNSORTED = 4'h0;
    localparam logic [CLASS_W-1:0] CLASS_SECONDARY_FAIL = 4'hA;
    localparam logic [CLASS_W-1:0] CLASS_OVERLOAD = 4'hB;

    typedef enum logic [1:0] {
        MODE_ABSOLUTE = 2'b00,
        ABSOLUTE_DEVIATION_MODE = 2'b01,
        MODE_PERCENT_DEVIATION = 2'b10
    } csc_limit_mode_type;

    typedef enum logic [2:0] {
        FREQ_100_120HZ = 3'b000,
        FREQ_1KHZ = 3'b001,
        FREQ_10KHZ = 3'b010,
        FREQ_100KHZ = 3'b011,
        FREQ_1MHZ = 3'b100
    } csc_freq_type;

    typedef enum logic [2:0] {
        ENTRY_NONE = 3'b000,
        ENTRY_WRITE_LOW = 3'b001,
        ENTRY_WRITE_HIGH = 3'b010,
        ENTRY_ENABLE_ON = 3'b011,
        ENTRY_ENABLE_OFF = 3'b100,
        ENTRY_CLEAR_LINE = 3'b101,
        ENTRY_CLEAR_TABLE = 3'b110
    } csc_entry_op_type;

endpackage

// file: csc_count_if.sv
// Interface between the comparator and its class counter store
`timescale 1ns/1ps
`default_nettype none
interface csc_count_if;
    logic incEn;
    logic [csc_pkg::COUNT_AW-1:0] incAddr;
    logic clearAll;
    logic rdEn;
    logic [csc_pkg::COUNT_AW-1:0] rdAddr;
    logic [csc_pkg::COUNT_W-1:0] rdData;
    modport owner (output incEn, output incAddr, output clearAll, output rdEn, output rdAddr,
        input rdData);
    modport store (input incEn, input incAddr, input clearAll, input rdEn, input rdAddr,
        output rdData);
endinterface
`default_nettype wire

// file: csc_count_mem.sv
// Saturating class counter store with registered read data
`timescale 1ns/1ps
`default_nettype none
module csc_count_mem
    import csc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    csc_count_if.store bus
);

    typedef struct packed {
        logic [COUNT_DEPTH-1:0][COUNT_W-1:0] count;
        logic [COUNT_W-1:0] rdData;
    } csc_mem_state_type;

    csc_mem_state_type st;
    csc_mem_state_type next_st;

    assign bus.rdData = st.rdData;

    always_comb
    begin
        next_st = st;
        // clear all counters
        // Clear wins over an increment in the same cycle
        if (bus.clearAll)
        begin
            for (int i = 0; i < COUNT_DEPTH; i++)
            begin
                next_st.count[i] = COUNT_RESET;
            end
        end
        else if (bus.incEn && (st.count[bus.incAddr] != COUNT_MAX))
        begin
            next_st.count[bus.incAddr] = st.count[bus.incAddr] + 20'h0_0001;
        end
        // Read returns the value before any same-cycle increment
        if (bus.rdEn)
        begin
            next_st.rdData = st.count[bus.rdAddr];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule // csc_count_mem
`default_nettype wire

// file: csc_sort_comparator.sv
// Sorting comparator: limit table, classification, low-value check and counters
//
// Overview of operation
// - A range whose upper bound is not above its lower bound is disabled.
// - Overlapping enabled ranges: the lowest-numbered match wins.
// - The reference value need not lie inside a deviation range.
// - Gaps allowed; a value matching no range gets no numbered class.
// - Warn whenever any lower bound exceeds its upper bound.
// - Nine primary ranges with enable and bounds; line clear erases and disables.
// - Lone lower entry copies to upper; lone upper entry negated to lower.
// - One secondary range with enable and bounds, checked besides the primary.
// - Class with secondary fail: unsorted or secondary-fail by select; no class is unsorted.
// - With low-value reject on, flag non-overload primary values at or below threshold.
// - Threshold is a percentage of full scale; fixed range uses selected range.
// - Auto range uses the frequency's minimum range as threshold reference.
// - Low value keeps classification, drives low flag, reports low status.
// - Overload is not classified and reports the unsortable status.
// - Class counters count while enabled and saturate at 999999.
// - Count reset clears every counter at once.
// - Separate count on and count off commands; counters hold when off.
// - Multi-channel mode keeps a counter set per channel, updating only the active one.
// - Overload events are counted, per channel in multi-channel mode.
// - Host queries the latest result and the device answers it.
// - Deviation modes add an absolute or percentage offset to the reference.
// - Secondary bounds are always absolute values.
// - Comparator off drives no class lines.
`timescale 1ns/1ps
`default_nettype none
module csc_sort_comparator
    import csc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic comparatorOn,
    input wire csc_pkg::csc_limit_mode_type limitMode,
    input wire logic signed [csc_pkg::VALUE_W-1:0] referenceValue,
    input wire logic secondaryRejectSelect,
    input wire csc_pkg::csc_entry_op_type entryOp,
    input wire logic [3:0] entryIndex,
    input wire logic signed [csc_pkg::VALUE_W-1:0] entryValue,
    input wire logic lowValueReject,
    input wire logic [csc_pkg::PCT_W-1:0] lowValuePercent,
    input wire logic autoRange,
    input wire logic [csc_pkg::VALUE_W-1:0] rangeFullScale,
    input wire csc_pkg::csc_freq_type testFreq,
    input wire logic measValid,
    input wire logic signed [csc_pkg::VALUE_W-1:0] primaryValue,
    input wire logic signed [csc_pkg::VALUE_W-1:0] secondaryValue,
    input wire logic overload,
    input wire logic multiChannelOn,
    input wire logic [csc_pkg::CHAN_W-1:0] channel,
    input wire logic countOn,
    input wire logic countOff,
    input wire logic countReset,
    input wire logic resultQuery,
    input wire logic countQuery,
    input wire logic [csc_pkg::CHAN_W-1:0] countQueryChannel,
    input wire logic [csc_pkg::CLASS_W-1:0] countQueryClass,
    output logic resultValid,
    output logic [csc_pkg::CLASS_W-1:0] sortClass,
    output logic lowValueStatus,
    output logic [csc_pkg::NUM_RANGES-1:0] sortClassLine_n,
    output logic unsortedLine_n,
    output logic secondaryFailLine_n,
    output logic overloadLine_n,
    output logic lowValueOrOpenFlag_n,
    output logic boundWarning,
    output logic countEnabled,
    output logic replyValid,
    output logic [csc_pkg::CLASS_W-1:0] replyClass,
    output logic replyLowValue,
    output logic countReplyValid,
    output logic [csc_pkg::COUNT_W-1:0] countReplyData
);

    typedef struct packed {
        logic [NUM_LIMITS-1:0][VALUE_W-1:0] lowBound;
        logic [NUM_LIMITS-1:0][VALUE_W-1:0] highBound;
        logic [NUM_LIMITS-1:0] lowEntered;
        logic [NUM_LIMITS-1:0] highEntered;
        logic [NUM_LIMITS-1:0] enable;
        logic countEnabled;
        logic resultValid;
        logic [CLASS_W-1:0] sortClass;
        logic lowValueStatus;
        logic [NUM_RANGES-1:0] sortClassLine_n;
        logic unsortedLine_n;
        logic secondaryFailLine_n;
        logic overloadLine_n;
        logic lowValueOrOpenFlag_n;
        logic boundWarning;
        logic replyValid;
        logic [CLASS_W-1:0] replyClass;
        logic replyLowValue;
        logic countReplyValid;
    } csc_top_state_type;

    csc_top_state_type st;
    csc_top_state_type next_st;
    csc_count_if cnt ();

    // deviation bound derivation
    // Percent math runs at 64 bits so large references do not overflow
    function automatic logic signed [VALUE_W-1:0] eff_bound(
        input csc_limit_mode_type mode,
        input logic signed [VALUE_W-1:0] reference_value,
        input logic signed [VALUE_W-1:0] b
    );
        logic signed [63:0] prod;
        prod = (64'(reference_value) * 64'(b)) / $signed(PCT_SCALE);
        case (mode)
            ABSOLUTE_DEVIATION_MODE: return reference_value + b;
            MODE_PERCENT_DEVIATION: return reference_value + $signed(prod[VALUE_W-1:0]);
            default: return b;
        endcase
    endfunction

    always_comb
    begin
        logic signed [VALUE_W-1:0] effLow [NUM_LIMITS];
        logic signed [VALUE_W-1:0] effHigh [NUM_LIMITS];
        logic [NUM_LIMITS-1:0] live;
        logic found;
        logic [CLASS_W-1:0] matchIdx;
        logic secPass;
        logic [CLASS_W-1:0] cls;
        logic [VALUE_W-1:0] fullScale;
        logic [63:0] thrWide;
        logic signed [VALUE_W-1:0] threshold;
        logic isLow;
        logic [CHAN_W-1:0] chanSel;
        logic [3:0] idx;
        for (int i = 0; i < NUM_LIMITS; i++)
        begin
            effLow[i] = '0;
            effHigh[i] = '0;
        end
        live = '0;
        found = 1'b0;
        matchIdx = '0;
        secPass = 1'b1;
        cls = CLASS_UNSORTED;
        fullScale = rangeFullScale;
        thrWide = '0;
        threshold = '0;
        isLow = 1'b0;
        chanSel = '0;
        idx = entryIndex;
        next_st = st;
        next_st.resultValid = 1'b0;
        next_st.replyValid = 1'b0;
        next_st.countReplyValid = 1'b0;

        // Limit table entry; indices above the secondary slot are ignored
        if (idx <= SEC_INDEX)
        begin
            case (entryOp)
                ENTRY_WRITE_LOW:
                begin
                    next_st.lowBound[idx] = entryValue;
                    next_st.lowEntered[idx] = 1'b1;
                    if (!st.highEntered[idx])
                    begin
                        next_st.highBound[idx] = entryValue;
                    end
                end
                ENTRY_WRITE_HIGH:
                begin
                    next_st.highBound[idx] = entryValue;
                    next_st.highEntered[idx] = 1'b1;
                    if (!st.lowEntered[idx])
                    begin
                        next_st.lowBound[idx] = -entryValue;
                    end
                end
                ENTRY_ENABLE_ON: next_st.enable[idx] = 1'b1;
                ENTRY_ENABLE_OFF: next_st.enable[idx] = 1'b0;
                ENTRY_CLEAR_LINE:
                begin
                    next_st.lowBound[idx] = BOUND_RESET;
                    next_st.highBound[idx] = BOUND_RESET;
                    next_st.lowEntered[idx] = 1'b0;
                    next_st.highEntered[idx] = 1'b0;
                    next_st.enable[idx] = 1'b0;
                end
                default: ;
            endcase
        end
        if (entryOp == ENTRY_CLEAR_TABLE)
        begin
            next_st.lowBound = '0;
            next_st.highBound = '0;
            next_st.lowEntered = '0;
            next_st.highEntered = '0;
            next_st.enable = '0;
        end

        // reference is never checked against the range
        for (int i = 0; i < NUM_LIMITS; i++)
        begin
            if (i < NUM_RANGES)
            begin
                effLow[i] = eff_bound(limitMode, referenceValue, st.lowBound[i]);
                effHigh[i] = eff_bound(limitMode, referenceValue, st.highBound[i]);
            end
            else
            begin
                effLow[i] = st.lowBound[i];
                effHigh[i] = st.highBound[i];
            end
            live[i] = st.enable[i] && (effHigh[i] > effLow[i]);
        end

        next_st.boundWarning = 1'b0;
        for (int i = 0; i < NUM_LIMITS; i++)
        begin
            if (effLow[i] > effHigh[i])
            begin
                next_st.boundWarning = 1'b1;
            end
        end

        for (int i = NUM_RANGES - 1; i >= 0; i--)
        begin
            if (live[i] && (primaryValue >= effLow[i]) && (primaryValue <= effHigh[i]))
            begin
                found = 1'b1;
                matchIdx = 4'(i);
            end
        end

        if (live[SEC_INDEX])
        begin
            secPass = (secondaryValue >= effLow[SEC_INDEX]) &&
                (secondaryValue <= effHigh[SEC_INDEX]);
        end

        if (overload)
        begin
            cls = CLASS_OVERLOAD;
        end
        else if (!found)
        begin
            cls = CLASS_UNSORTED;
        end
        else if (!secPass)
        begin
            cls = secondaryRejectSelect ? CLASS_SECONDARY_FAIL : CLASS_UNSORTED;
        end
        else
        begin
            cls = matchIdx + 4'h1;
        end

        if (autoRange)
        begin
            case (testFreq)
                FREQ_100_120HZ: fullScale = MIN_RANGE_10NF;
                FREQ_1KHZ: fullScale = MIN_RANGE_100PF;
                FREQ_10KHZ: fullScale = MIN_RANGE_100PF;
                FREQ_100KHZ: fullScale = MIN_RANGE_100PF;
                FREQ_1MHZ: fullScale = MIN_RANGE_1PF;
                default: fullScale = rangeFullScale;
            endcase
        end
        thrWide = (64'(fullScale) * 64'(lowValuePercent)) / PCT_SCALE;
        threshold = $signed(thrWide[VALUE_W-1:0]);
        isLow = lowValueReject && !overload && (primaryValue <= threshold);

        if (measValid)
        begin
            next_st.resultValid = 1'b1;
            next_st.sortClass = cls;
            next_st.lowValueStatus = isLow;
            next_st.sortClassLine_n = '1;
            next_st.unsortedLine_n = 1'b1;
            next_st.secondaryFailLine_n = 1'b1;
            next_st.overloadLine_n = 1'b1;
            next_st.lowValueOrOpenFlag_n = 1'b1;
            if (comparatorOn)
            begin
                if ((cls != CLASS_UNSORTED) && (cls <= 4'(NUM_RANGES)))
                begin
                    next_st.sortClassLine_n[cls - 4'h1] = 1'b0;
                end
                next_st.unsortedLine_n = (cls != CLASS_UNSORTED);
                next_st.secondaryFailLine_n = (cls != CLASS_SECONDARY_FAIL);
                next_st.overloadLine_n = (cls != CLASS_OVERLOAD);
                next_st.lowValueOrOpenFlag_n = !isLow;
            end
        end
        if (!comparatorOn)
        begin
            next_st.sortClassLine_n = '1;
            next_st.unsortedLine_n = 1'b1;
            next_st.secondaryFailLine_n = 1'b1;
            next_st.overloadLine_n = 1'b1;
            next_st.lowValueOrOpenFlag_n = 1'b1;
        end

        // count on and off
        // Off wins if both arrive together
        if (countOff)
        begin
            next_st.countEnabled = 1'b0;
        end
        else if (countOn)
        begin
            next_st.countEnabled = 1'b1;
        end

        chanSel = multiChannelOn ? channel : '0;
        cnt.incEn = measValid && st.countEnabled;
        cnt.incAddr = {chanSel, cls};
        cnt.clearAll = countReset;
        cnt.rdEn = countQuery;
        cnt.rdAddr = {countQueryChannel, countQueryClass};
        next_st.countReplyValid = countQuery;

        if (resultQuery)
        begin
            next_st.replyValid = 1'b1;
            next_st.replyClass = st.sortClass;
            next_st.replyLowValue = st.lowValueStatus;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.sortClassLine_n <= '1;
            st.unsortedLine_n <= 1'b1;
            st.secondaryFailLine_n <= 1'b1;
            st.overloadLine_n <= 1'b1;
            st.lowValueOrOpenFlag_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    csc_count_mem countStore (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus(cnt.store)
    );

    assign resultValid = st.resultValid;
    assign sortClass = st.sortClass;
    assign lowValueStatus = st.lowValueStatus;
    assign sortClassLine_n = st.sortClassLine_n;
    assign unsortedLine_n = st.unsortedLine_n;
    assign secondaryFailLine_n = st.secondaryFailLine_n;
    assign overloadLine_n = st.overloadLine_n;
    assign lowValueOrOpenFlag_n = st.lowValueOrOpenFlag_n;
    assign boundWarning = st.boundWarning;
    assign countEnabled = st.countEnabled;
    assign replyValid = st.replyValid;
    assign replyClass = st.replyClass;
    assign replyLowValue = st.replyLowValue;
    assign countReplyValid = st.countReplyValid;
    assign countReplyData = cnt.rdData;

endmodule // csc_sort_comparator
`default_nettype wire

// file: csc_sort_comparator_properties.sv
// Port-level assertions for the sorting comparator
`timescale 1ns/1ps
`default_nettype none
module csc_sort_checker
    import csc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic comparatorOn,
    input wire logic measValid,
    input wire logic overload,
    input wire logic resultQuery,
    input wire logic countQuery,
    input wire logic resultValid,
    input wire logic [csc_pkg::CLASS_W-1:0] sortClass,
    input wire logic lowValueStatus,
    input wire logic [csc_pkg::NUM_RANGES-1:0] sortClassLine_n,
    input wire logic unsortedLine_n,
    input wire logic secondaryFailLine_n,
    input wire logic overloadLine_n,
    input wire logic lowValueOrOpenFlag_n,
    input wire logic replyValid,
    input wire logic [csc_pkg::CLASS_W-1:0] replyClass,
    input wire logic countReplyValid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Lines follow the comparator switch one cycle late
    sequence s_meas_on;
        measValid && comparatorOn;
    endsequence
    sequence s_out_on;
        resultValid && $past(comparatorOn);
    endsequence
    a_result_pulse: assert property (measValid |=> resultValid)
        else $error("result not one cycle after measurement");
    a_result_held: assert property (!measValid |=> !resultValid && $stable(sortClass))
        else $error("result changed without measurement");
    a_overload_class: assert property (measValid && overload |=>
        sortClass == CLASS_OVERLOAD && !lowValueStatus)
        else $error("overload not reported as unsortable");
    a_overload_line: assert property (s_meas_on ##0 overload |=>
        !overloadLine_n && &sortClassLine_n)
        else $error("overload line wrong");
    a_off_lines_high: assert property (!comparatorOn |=>
        &sortClassLine_n && unsortedLine_n && secondaryFailLine_n
        && overloadLine_n && lowValueOrOpenFlag_n)
        else $error("lines driven with comparator off");
    a_low_flag_match: assert property (s_out_on |->
        lowValueOrOpenFlag_n == !lowValueStatus)
        else $error("low flag disagrees with status");
    a_class_line_one: assert property (s_out_on ##0 (sortClass inside {[1:9]}) |->
        sortClassLine_n == ~(9'h001 << (sortClass - 1)))
        else $error("class line not matching class");
    a_unsorted_line: assert property (s_out_on ##0 sortClass == CLASS_UNSORTED |->
        !unsortedLine_n && &sortClassLine_n)
        else $error("unsorted line wrong");
    a_reply_class: assert property (resultQuery |=>
        replyValid && replyClass == $past(sortClass))
        else $error("result reply wrong");
    a_count_reply: assert property (countQuery |=> countReplyValid)
        else $error("count reply missing");
endmodule // csc_sort_checker
bind csc_sort_comparator csc_sort_checker u_csc_sort_checker (.*);
`default_nettype wire

// file: csc_host_model.sv
// Host controller model issuing result and count queries
`timescale 1ns/1ps
`default_nettype none
module csc_host_model
    import csc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic replyValid,
    input wire logic [csc_pkg::CLASS_W-1:0] replyClass,
    input wire logic countReplyValid,
    input wire logic [csc_pkg::COUNT_W-1:0] countReplyData,
    output logic resultQuery,
    output logic countQuery,
    output logic [csc_pkg::CHAN_W-1:0] countQueryChannel,
    output logic [csc_pkg::CLASS_W-1:0] countQueryClass
);
    initial
    begin
        resultQuery = 1'b0;
        countQuery = 1'b0;
        countQueryChannel = 2'h0;
        countQueryClass = 4'h0;
    end
    task automatic ask_result(output logic [CLASS_W-1:0] cls);
        @(posedge ref_clk);
        resultQuery <= 1'b1;
        @(posedge ref_clk);
        resultQuery <= 1'b0;
        #1;
        cls = replyValid === 1'b1 ? replyClass : 'x;
    endtask
    // count query, no reply reads unknown
    task automatic ask_count(input logic [CHAN_W-1:0] ch, input logic [CLASS_W-1:0] cls,
        output logic [COUNT_W-1:0] data);
        @(posedge ref_clk);
        countQuery <= 1'b1;
        countQueryChannel <= ch;
        countQueryClass <= cls;
        @(posedge ref_clk);
        countQuery <= 1'b0;
        #1;
        data = countReplyValid === 1'b1 ? countReplyData : 'x;
    endtask
endmodule // csc_host_model
`default_nettype wire

// file: csc_sort_comparator_tb_top.sv
// Self-checking bench for the sorting comparator
`timescale 1ns/1ps
`default_nettype none
module csc_sort_comparator_tb_top;
    import csc_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, comparatorOn = 1'b1, secondaryRejectSelect = 1'b0;
    logic lowValueReject = 1'b0, autoRange = 1'b0, measValid = 1'b0, overload = 1'b0;
    logic multiChannelOn = 1'b0, countOn = 1'b0, countOff = 1'b0, countReset = 1'b0;
    csc_limit_mode_type limitMode = MODE_ABSOLUTE;
    csc_entry_op_type entryOp = ENTRY_NONE;
    csc_freq_type testFreq = FREQ_100_120HZ;
    logic [3:0] entryIndex = 4'h0;
    logic signed [VALUE_W-1:0] referenceValue = 32'h0000_0000, entryValue = 32'h0000_0000;
    logic signed [VALUE_W-1:0] primaryValue = 32'h0000_0000, secondaryValue = 32'h0000_0000;
    logic [PCT_W-1:0] lowValuePercent = 16'h0064;
    logic [VALUE_W-1:0] rangeFullScale = 32'h0000_2710;
    logic [CHAN_W-1:0] channel = 2'h0, countQueryChannel;
    logic resultQuery, countQuery, resultValid, lowValueStatus, unsortedLine_n, replyValid;
    logic secondaryFailLine_n, overloadLine_n, lowValueOrOpenFlag_n, boundWarning, countEnabled;
    logic replyLowValue, countReplyValid, cntOn;
    logic [CLASS_W-1:0] countQueryClass, sortClass, replyClass, got;
    logic [NUM_RANGES-1:0] sortClassLine_n;
    logic [COUNT_W-1:0] countReplyData;
    int fails = 0, checked = 0, cycles = 0;
    int expCnt [COUNT_DEPTH] = '{default: 0};
    int thr [5] = '{100000, 1000, 1000, 1000, 10};
    csc_sort_comparator u_csc_sort_comparator (.*);
    csc_host_model u_csc_host_model (.*);
    always #10 ref_clk = ~ref_clk;
    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Table is tiny, so a few thousand cycles is ample
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic entry(input csc_entry_op_type op, input int idx, input int val);
        @(posedge ref_clk);
        entryOp <= op;
        entryIndex <= 4'(idx);
        entryValue <= val;
        @(posedge ref_clk);
        entryOp <= ENTRY_NONE;
    endtask
    task automatic rng(input int idx, input int lo, input int hi);
        entry(ENTRY_WRITE_LOW, idx, lo);
        entry(ENTRY_WRITE_HIGH, idx, hi);
        entry(ENTRY_ENABLE_ON, idx, 0);
    endtask
    // Expected counts tracked here, saturation never reached in this run
    task automatic meas(input int p, input int s, input logic ov, input logic [3:0] cls,
        input logic low);
        @(posedge ref_clk);
        measValid <= 1'b1;
        primaryValue <= p;
        secondaryValue <= s;
        overload <= ov;
        @(posedge ref_clk);
        measValid <= 1'b0;
        if (cntOn)
            expCnt[{multiChannelOn ? channel : 2'h0, cls}]++;
        #1;
        chk("resultValid", 1, resultValid);
        chk("sortClass", cls, sortClass);
        chk("lowValueStatus", low, lowValueStatus);
    endtask
    task automatic chk_counts();
        logic [COUNT_W-1:0] d;
        for (int i = 0; i < COUNT_DEPTH; i++)
        begin
            u_csc_host_model.ask_count(i[5:4], i[3:0], d);
            chk("classCount", expCnt[i], d);
        end
    endtask
    initial
    begin
        cntOn = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        countOn <= 1'b1;
        @(posedge ref_clk);
        countOn <= 1'b0;
        cntOn = 1'b1;
        #1;
        chk("countEnabled", 1, countEnabled);
        entry(ENTRY_WRITE_LOW, 0, 100);
        entry(ENTRY_ENABLE_ON, 0, 0);
        meas(100, 0, 0, 0, 0);
        entry(ENTRY_WRITE_HIGH, 0, 200);
        meas(100, 0, 0, 1, 0);
        meas(200, 0, 0, 1, 0);
        meas(201, 0, 0, 0, 0);
        entry(ENTRY_WRITE_HIGH, 1, 50);
        entry(ENTRY_ENABLE_ON, 1, 0);
        meas(-50, 0, 0, 2, 0);
        rng(2, 150, 300);
        meas(150, 0, 0, 1, 0);
        meas(250, 0, 0, 3, 0);
        rng(3, 500, 400);
        meas(450, 0, 0, 0, 0);
        chk("boundWarning", 1, boundWarning);
        entry(ENTRY_CLEAR_LINE, 3, 0);
        entry(ENTRY_CLEAR_LINE, 0, 0);
        meas(100, 0, 0, 0, 0);
        chk("boundWarning", 0, boundWarning);
        rng(0, 100, 200);
        rng(9, 0, 10);
        meas(100, 20, 0, 0, 0);
        @(posedge ref_clk) secondaryRejectSelect <= 1'b1;
        meas(100, 20, 0, 4'hA, 0);
        chk("secondaryFailLine_n", 0, secondaryFailLine_n);
        meas(100, 5, 0, 1, 0);
        meas(1000, 20, 0, 0, 0);
        meas(100, 5, 1, 4'hB, 0);
        u_csc_host_model.ask_result(got);
        chk("replyClass", 4'hB, got);
        chk("replyLowValue", 0, replyLowValue);
        @(posedge ref_clk) comparatorOn <= 1'b0;
        meas(100, 5, 0, 1, 0);
        chk("sortClassLine_n", 9'h1FF, sortClassLine_n);
        @(posedge ref_clk);
        comparatorOn <= 1'b1;
        lowValueReject <= 1'b1;
        meas(100, 5, 0, 1, 1);
        chk("lowValueOrOpenFlag_n", 0, lowValueOrOpenFlag_n);
        u_csc_host_model.ask_result(got);
        chk("replyClass", 1, got);
        chk("replyLowValue", 1, replyLowValue);
        meas(101, 5, 0, 1, 0);
        meas(50, 5, 1, 4'hB, 0);
        entry(ENTRY_CLEAR_TABLE, 0, 0);
        @(posedge ref_clk) autoRange <= 1'b1;
        for (int f = 0; f < 5; f++)
        begin
            @(posedge ref_clk) testFreq <= csc_freq_type'(f);
            meas(thr[f], 0, 0, 0, 1);
            meas(thr[f] + 1, 0, 0, 0, 0);
        end
        @(posedge ref_clk);
        lowValueReject <= 1'b0;
        limitMode <= ABSOLUTE_DEVIATION_MODE;
        referenceValue <= 1000;
        rng(0, -20, -10);
        rng(9, 0, 10);
        meas(985, 5, 0, 1, 0);
        meas(1000, 5, 0, 0, 0);
        @(posedge ref_clk) limitMode <= MODE_PERCENT_DEVIATION;
        rng(0, -200, -100);
        meas(980, 5, 0, 1, 0);
        meas(991, 5, 0, 0, 0);
        @(posedge ref_clk) countOff <= 1'b1;
        @(posedge ref_clk) countOff <= 1'b0;
        cntOn = 1'b0;
        meas(985, 5, 0, 1, 0);
        @(posedge ref_clk);
        multiChannelOn <= 1'b1;
        channel <= 2'h2;
        countOn <= 1'b1;
        @(posedge ref_clk) countOn <= 1'b0;
        cntOn = 1'b1;
        meas(985, 5, 0, 1, 0);
        meas(985, 5, 1, 4'hB, 0);
        chk_counts();
        @(posedge ref_clk) countReset <= 1'b1;
        @(posedge ref_clk) countReset <= 1'b0;
        expCnt = '{default: 0};
        chk_counts();
        wrap_up();
    end
endmodule // csc_sort_comparator_tb_top
`default_nettype wire
